// [logic/cbo_regs.sv]
// command register and host bus ownership register
// assumes a host register port already decoded from the host interface,
// and internal sequencers that report command completion and wake-up
//
// Function
// - top command bit powers whole device down
// - bit six powers down radio only
// - low five bits hold command, write starts
// - code and power-down overwritten by internal logic
// - command register at address 00h, bit5 reserved
// - unlock bit permits next ownership change
// - first following write clears unlock bit
// - bit six set makes host owner
// - bit five set makes module owner
// - both ownership bits never one together
// - ownership change needs prior unlock
// - bits 3..2 select module interface type
// - ownership register at 01h, bits 4,1,0 reserved
`include "cbo_consts.svh"

module cbo_regs
  import cbo_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        SYS_RST_IN,
  // host register port
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [7:0]  REG_RDATA_OUT,
  output logic             REG_RVALID_OUT,
  // internal sequencer side
  input  wire logic        CMD_DONE_IN,
  input  wire logic        WAKE_IN,
  output logic             CMD_START_OUT,
  output logic      [4:0]  CMD_CODE_OUT,
  // power control
  output logic             POWER_DOWN_OUT,
  output logic             RADIO_POWER_DOWN_OUT,
  // bus ownership and module interface
  output logic             OWNER_IS_HOST_OUT,
  output logic             OWNER_IS_MODULE_OUT,
  output logic      [1:0]  MODULE_IF_SELECT_OUT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cbo_req_t   req;
  cbo_state_t cur_ff;
  cbo_state_t nxt_ff;
  logic       wr_cmd;
  logic       wr_own;
  logic       ask_host;
  logic       ask_mod;

  // reset images kept whole so each field is cut from a named value
  localparam logic [7:0] cmd_rst_val = `CBO_CMD_RESET;
  localparam logic [7:0] own_rst_val = `CBO_OWN_RESET;

  assign req.addr  = REG_ADDR_IN;
  assign req.wdata = REG_WDATA_IN;
  assign req.wr    = REG_WR_IN;
  assign req.rd    = REG_RD_IN;

  assign wr_cmd   = req.wr && (req.addr == `CBO_ADDR_CMD);
  assign wr_own   = req.wr && (req.addr == `CBO_ADDR_OWN);
  assign ask_host = req.wdata[`CBO_OWN_HOST_BIT];
  assign ask_mod  = req.wdata[`CBO_OWN_MOD_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ff        = cur_ff;
    nxt_ff.start  = 1'b0;
    nxt_ff.rvalid = req.rd;

    // internal sequencers; a host write in the same cycle wins
    if (CMD_DONE_IN) begin
      nxt_ff.cmd_code = `CBO_CODE_IDLE;
    end
    if (WAKE_IN) begin
      nxt_ff.power_down = 1'b0;
    end

    if (wr_cmd) begin
      nxt_ff.power_down       = req.wdata[`CBO_CMD_PD_BIT];
      nxt_ff.radio_power_down = req.wdata[`CBO_CMD_RADIO_BIT];
      nxt_ff.cmd_code =
        req.wdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO];
      nxt_ff.start = 1'b1;
    end

    // any write consumes an armed unlock
    if (req.wr && cur_ff.unlock_once) begin
      nxt_ff.unlock_once = 1'b0;
    end

    if (wr_own) begin
      nxt_ff.module_if_select =
        cbo_if_sel_t'(req.wdata[`CBO_OWN_SEL_HI:`CBO_OWN_SEL_LO]);
      if (cur_ff.unlock_once) begin
        // both requested is refused, the old owner stays
        if (!(ask_host && ask_mod)) begin
          nxt_ff.owner_is_host   = ask_host;
          nxt_ff.owner_is_module = ask_mod;
        end
      end else begin
        nxt_ff.unlock_once = req.wdata[`CBO_OWN_UNLOCK_BIT];
      end
    end

    // reads: reserved bits return zero
    nxt_ff.rdata = `CBO_RDATA_ZERO;
    if (req.rd && req.addr == `CBO_ADDR_CMD) begin
      nxt_ff.rdata[`CBO_CMD_PD_BIT]    = cur_ff.power_down;
      nxt_ff.rdata[`CBO_CMD_RADIO_BIT] = cur_ff.radio_power_down;
      nxt_ff.rdata[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO] = cur_ff.cmd_code;
    end else if (req.rd && req.addr == `CBO_ADDR_OWN) begin
      nxt_ff.rdata[`CBO_OWN_UNLOCK_BIT] = cur_ff.unlock_once;
      nxt_ff.rdata[`CBO_OWN_HOST_BIT]   = cur_ff.owner_is_host;
      nxt_ff.rdata[`CBO_OWN_MOD_BIT]    = cur_ff.owner_is_module;
      nxt_ff.rdata[`CBO_OWN_SEL_HI:`CBO_OWN_SEL_LO] = cur_ff.module_if_select;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      cur_ff.cmd_code         <= cmd_rst_val[`CBO_CMD_CODE_HI:`CBO_CMD_CODE_LO];
      cur_ff.power_down       <= cmd_rst_val[`CBO_CMD_PD_BIT];
      cur_ff.radio_power_down <= cmd_rst_val[`CBO_CMD_RADIO_BIT];
      cur_ff.start            <= 1'b0;
      cur_ff.unlock_once      <= own_rst_val[`CBO_OWN_UNLOCK_BIT];
      cur_ff.owner_is_host    <= own_rst_val[`CBO_OWN_HOST_BIT];
      cur_ff.owner_is_module  <= own_rst_val[`CBO_OWN_MOD_BIT];
      cur_ff.module_if_select <= cbo_if_sel_t'(own_rst_val[`CBO_OWN_SEL_HI:`CBO_OWN_SEL_LO]);
      cur_ff.rdata            <= `CBO_RDATA_ZERO;
      cur_ff.rvalid           <= 1'b0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_OUT        = cur_ff.rdata;
  assign REG_RVALID_OUT       = cur_ff.rvalid;
  assign CMD_START_OUT        = cur_ff.start;
  assign CMD_CODE_OUT         = cur_ff.cmd_code;
  assign POWER_DOWN_OUT       = cur_ff.power_down;
  assign RADIO_POWER_DOWN_OUT = cur_ff.radio_power_down;
  assign OWNER_IS_HOST_OUT    = cur_ff.owner_is_host;
  assign OWNER_IS_MODULE_OUT  = cur_ff.owner_is_module;
  assign MODULE_IF_SELECT_OUT = cur_ff.module_if_select;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  sequence s_arm;
    wr_own && !cur_ff.unlock_once && REG_WDATA_IN[7];
  endsequence

  sequence s_own_write;
    wr_own && !(REG_WDATA_IN[6] && REG_WDATA_IN[5]);
  endsequence

  a_standby_write: assert property (
    wr_cmd |=> POWER_DOWN_OUT == $past(REG_WDATA_IN[7]))
    else $error("power-down bit does not follow write");

  a_radio_off: assert property (
    wr_cmd |=> RADIO_POWER_DOWN_OUT == $past(REG_WDATA_IN[6]))
    else $error("radio power-down bit does not follow write");

  a_cmd_start: assert property (
    wr_cmd |=> CMD_START_OUT && CMD_CODE_OUT == $past(REG_WDATA_IN[4:0]))
    else $error("command write did not start command");

  a_done_idle: assert property (
    CMD_DONE_IN && !wr_cmd |=> CMD_CODE_OUT == `CBO_CODE_IDLE)
    else $error("command code not idle after completion");

  a_cmd_readback: assert property (
    REG_RD_IN && REG_ADDR_IN == `CBO_ADDR_CMD && !REG_WR_IN
      |=> REG_RVALID_OUT && REG_RDATA_OUT[5] == 1'b0
          && REG_RDATA_OUT[4:0] == $past(CMD_CODE_OUT))
    else $error("command register read back wrong");

  a_unlock_arms: assert property (
    s_arm |=> OWNER_IS_HOST_OUT == $past(OWNER_IS_HOST_OUT)
      ##0 cur_ff.unlock_once)
    else $error("unlock did not arm");

  a_unlock_once: assert property (
    cur_ff.unlock_once && REG_WR_IN |=> !cur_ff.unlock_once)
    else $error("unlock survived a write");

  a_host_owner: assert property (
    cur_ff.unlock_once ##0 s_own_write |=> OWNER_IS_HOST_OUT == $past(REG_WDATA_IN[6]))
    else $error("host ownership not taken");

  a_module_owner: assert property (
    cur_ff.unlock_once ##0 s_own_write |=> OWNER_IS_MODULE_OUT == $past(REG_WDATA_IN[5]))
    else $error("module ownership not taken");

  a_owner_excl: assert property (
    !(OWNER_IS_HOST_OUT && OWNER_IS_MODULE_OUT))
    else $error("both owners set");

  a_owner_locked: assert property (
    wr_own && !cur_ff.unlock_once |=> $stable(OWNER_IS_HOST_OUT)
      && $stable(OWNER_IS_MODULE_OUT))
    else $error("ownership changed while locked");

  a_if_select: assert property (
    wr_own |=> MODULE_IF_SELECT_OUT == $past(REG_WDATA_IN[3:2]))
    else $error("interface select not written");

  a_own_reserved: assert property (
    REG_RD_IN && REG_ADDR_IN == `CBO_ADDR_OWN
      |=> REG_RDATA_OUT[4] == 1'b0 && REG_RDATA_OUT[1:0] == 2'h0)
    else $error("reserved bits read nonzero");

  a_reset_zero: assert property (
    disable iff (1'b0) SYS_RST_IN |=> CMD_CODE_OUT == `CBO_CODE_IDLE
      && !POWER_DOWN_OUT && !OWNER_IS_HOST_OUT && MODULE_IF_SELECT_OUT == 2'h0)
    else $error("registers not zero after reset");

  // ----------------------------------------------------------------
  // hold checks: fields move only on their own write or event
  // ----------------------------------------------------------------
  // radio power-down is plain read/write, no sequencer may touch it
  a_radio_hold: assert property (
    !wr_cmd |=> $stable(RADIO_POWER_DOWN_OUT))
    else $error("radio power-down moved without a write");

  a_pd_hold: assert property (
    !wr_cmd && !WAKE_IN |=> $stable(POWER_DOWN_OUT))
    else $error("power-down moved without a write or wake");

  a_code_hold: assert property (
    !wr_cmd && !CMD_DONE_IN |=> $stable(CMD_CODE_OUT))
    else $error("command code moved without a write or completion");

  a_start_pulse: assert property (
    !wr_cmd |=> !CMD_START_OUT)
    else $error("command start without a write");

  a_wake_clear: assert property (
    WAKE_IN && !wr_cmd |=> !POWER_DOWN_OUT)
    else $error("power-down not cleared by wake");

  a_owner_hold: assert property (
    !wr_own |=> $stable(OWNER_IS_HOST_OUT) && $stable(OWNER_IS_MODULE_OUT))
    else $error("ownership moved without a write");

  a_select_hold: assert property (
    !wr_own |=> $stable(MODULE_IF_SELECT_OUT))
    else $error("interface select moved without a write");

  // ----------------------------------------------------------------
  // unlock and ownership guards
  // ----------------------------------------------------------------
  sequence s_ask_both;
    wr_own && REG_WDATA_IN[`CBO_OWN_HOST_BIT] && REG_WDATA_IN[`CBO_OWN_MOD_BIT];
  endsequence

  // only an arming write may raise the unlock bit; reads never do
  a_unlock_stays: assert property (
    !cur_ff.unlock_once && !(wr_own && REG_WDATA_IN[`CBO_OWN_UNLOCK_BIT])
      |=> !cur_ff.unlock_once)
    else $error("unlock armed without an arming write");

  // a refused double request must not disturb a standing owner
  a_both_refused: assert property (
    cur_ff.unlock_once ##0 s_ask_both
      |=> $stable(OWNER_IS_HOST_OUT) && $stable(OWNER_IS_MODULE_OUT))
    else $error("double ownership request changed the owner");

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // the answer is a one-cycle pulse; the data bus idles at zero
  a_read_idle: assert property (
    !REG_RD_IN |=> !REG_RVALID_OUT && REG_RDATA_OUT == `CBO_RDATA_ZERO)
    else $error("read answer without a read");

  a_own_readback: assert property (
    REG_RD_IN && REG_ADDR_IN == `CBO_ADDR_OWN
      |=> REG_RDATA_OUT[`CBO_OWN_UNLOCK_BIT] == $past(cur_ff.unlock_once)
          && REG_RDATA_OUT[`CBO_OWN_HOST_BIT] == $past(OWNER_IS_HOST_OUT)
          && REG_RDATA_OUT[`CBO_OWN_MOD_BIT] == $past(OWNER_IS_MODULE_OUT)
          && REG_RDATA_OUT[`CBO_OWN_SEL_HI:`CBO_OWN_SEL_LO] == $past(MODULE_IF_SELECT_OUT))
    else $error("ownership register read back wrong");

endmodule : cbo_regs

// [logic/cbo_consts.svh]
// constants for the command and bus ownership register pair
// assumes inclusion by bare name from the design
`ifndef CBO_CONSTS_SVH
`define CBO_CONSTS_SVH

// register addresses
`define CBO_ADDR_CMD       8'h00
`define CBO_ADDR_OWN       8'h01

// command register fields
`define CBO_CMD_PD_BIT     7
`define CBO_CMD_RADIO_BIT  6
`define CBO_CMD_CODE_HI    4
`define CBO_CMD_CODE_LO    0

// ownership register fields
`define CBO_OWN_UNLOCK_BIT 7
`define CBO_OWN_HOST_BIT   6
`define CBO_OWN_MOD_BIT    5
`define CBO_OWN_SEL_HI     3
`define CBO_OWN_SEL_LO     2

// reset values and idle command code
`define CBO_CMD_RESET      8'h00
`define CBO_OWN_RESET      8'h00
`define CBO_CODE_IDLE      5'h00
`define CBO_RDATA_ZERO     8'h00

`endif

// [logic/cbo_pkg.sv]
// types for the command and bus ownership register pair
// assumes cbo_consts.svh is on the include path
package cbo_pkg;

  // module interface selection codes
  typedef enum logic [1:0] {
    CBO_IF_OFF    = 2'h0,
    CBO_IF_SPI    = 2'h1,
    CBO_IF_I2C_LS = 2'h2,
    CBO_IF_I2C    = 2'h3
  } cbo_if_sel_t;

  // host register access request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cbo_req_t;

  // complete state of the register pair
  typedef struct packed {
    logic [4:0]  cmd_code;
    logic        power_down;
    logic        radio_power_down;
    logic        start;
    logic        unlock_once;
    logic        owner_is_host;
    logic        owner_is_module;
    cbo_if_sel_t module_if_select;
    logic [7:0]  rdata;
    logic        rvalid;
  } cbo_state_t;

endpackage : cbo_pkg

// [dv/cbo_seq_model.sv]
// sequencer stand-in behind the command register
// assumes one clock and a synchronous active-high reset
module cbo_seq_model #(
  parameter int DONE_DLY = 4
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // requests
  input  wire logic start_in,
  input  wire logic wake_req_in,
  // answers
  output logic      done_out,
  output logic      wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DONE_DLY-1:0] pipe_ff;
  // a fixed latency keeps the code check times predictable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pipe_ff  <= '0;
      wake_out <= 1'b0;
    end else begin
      pipe_ff  <= {pipe_ff[DONE_DLY-2:0], start_in};
      wake_out <= wake_req_in;
    end
  end
  assign done_out = pipe_ff[DONE_DLY-1];
endmodule : cbo_seq_model

// [dv/cbo_regs_test.sv]
// self-checking bench for the command and ownership registers
// assumes the sequencer model answers each start after four cycles
module cbo_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // signals
  // ----
  logic       clk, rst, wr, rd, wake_req, rvalid, done, wake, start, pd, rpd, oh, om;
  logic [7:0] addr, wdata, rdata;
  logic [4:0] code;
  logic [1:0] sel;
  int         mismatches, total_checks;
  cbo_regs i_dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .CMD_DONE_IN(done), .WAKE_IN(wake),
    .CMD_START_OUT(start), .CMD_CODE_OUT(code), .POWER_DOWN_OUT(pd),
    .RADIO_POWER_DOWN_OUT(rpd), .OWNER_IS_HOST_OUT(oh),
    .OWNER_IS_MODULE_OUT(om), .MODULE_IF_SELECT_OUT(sel));
  cbo_seq_model i_seq (.clk_in(clk), .rst_in(rst), .start_in(start),
    .wake_req_in(wake_req), .done_out(done), .wake_out(wake));
  // ----
  // tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one idle cycle first so no strobe is raised in the step that lowered it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", exp, rdata);
  endtask : rd_reg
  function automatic logic [7:0] own_pins();
    return {1'b0, oh, om, 1'b0, sel, 2'b00};
  endfunction : own_pins
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    chk("cmd pins", 8'h00, {pd, rpd, start, code});
    chk("own pins", 8'h00, own_pins());
    rd_reg(8'h00, 8'h00);
    rd_reg(8'h01, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_cmd();
    wr_reg(8'h00, 8'h05);
    chk("start code", 8'h25, {2'b00, start, code});
    cyc(8);
    chk("code done", 8'h00, {3'b000, code});
    wr_reg(8'h00, 8'hDF);
    chk("cmd pins", 8'hDF, {pd, rpd, 1'b0, code});
    rd_reg(8'h00, 8'hDF);
    cyc(8);
    rd_reg(8'h00, 8'hC0);
    wake_req = 1'b1;
    cyc(1);
    wake_req = 1'b0;
    rd_reg(8'h00, 8'h40);
    wr_reg(8'h00, 8'h00);
    $display("test command done");
  endtask : t_cmd
  task automatic t_own();
    wr_reg(8'h01, 8'h44);
    rd_reg(8'h01, 8'h04);
    wr_reg(8'h01, 8'h84);
    rd_reg(8'h01, 8'h84);
    wr_reg(8'h01, 8'h44);
    chk("own pins", 8'h44, own_pins());
    rd_reg(8'h01, 8'h44);
    wr_reg(8'h01, 8'h80);
    wr_reg(8'h01, 8'h6C);
    rd_reg(8'h01, 8'h4C);
    wr_reg(8'h01, 8'h80);
    wr_reg(8'h00, 8'h00);
    wr_reg(8'h01, 8'h20);
    rd_reg(8'h01, 8'h40);
    wr_reg(8'h01, 8'h80);
    wr_reg(8'h01, 8'h20);
    chk("own pins", 8'h20, own_pins());
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h01, 8'(i << 2));
      chk("select", 8'(i), {6'h00, sel});
    end
    rd_reg(8'h02, 8'h00);
    $display("test ownership done");
  endtask : t_own
  // reset in mid-run must clear state that earlier tests left behind
  task automatic t_mid_reset();
    wr_reg(8'h00, 8'hC3);
    chk("cmd pins", 8'hE3, {pd, rpd, start, code});
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk("cmd pins", 8'h00, {pd, rpd, start, code});
    chk("own pins", 8'h00, own_pins());
    rd_reg(8'h00, 8'h00);
    rd_reg(8'h01, 8'h00);
    $display("test mid reset done");
  endtask : t_mid_reset
  // ----
  // main sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {wr, rd, wake_req} = 3'h0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_cmd();
    t_own();
    t_mid_reset();
    print_verdict();
  end
  // whole run needs about 90 cycles
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule : cbo_regs_test
